// ==== src/pfm_map.svh ====
// Reset values, widths and pipeline depths for the port 1 / port 2 pin function mux
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH
`define PFM_PORT_W 8
`define PFM_LATCH_RST 8'hff
`define PFM_ADDR_W 20
`define PFM_P2_ADDR_LSB 12
`define PFM_LINES_W 4
`define PFM_LINES_RST 4'h0
`define PFM_LINES_MAX 4'h8
`define PFM_BUS16_RST 1'b0
`define PFM_PIN_ADDR0 0
`define PFM_PIN_RX 4
`define PFM_PIN_TX 5
`define PFM_PIN_TMR_IN 6
`define PFM_PIN_TMR_CTL 7
`define PFM_SYNC_LAT 3
`endif

// ==== src/pfm_pkg.sv ====
// Types shared by the port 1 / port 2 pin function mux
package pfm_pkg;
  // Output configuration of one pin
  typedef enum logic [1:0] {
    PFM_QUASI,
    PFM_OPEN_DRAIN,
    PFM_PUSH_PULL,
    PFM_INPUT_ONLY
  } pfm_otype_e;

  // Software side: port latches, per-pin output type, address line count
  typedef struct packed {
    logic p1_latch_we;
    logic p2_latch_we;
    logic [7:0] latch_data;
    logic type_we;
    logic type_port;
    logic [2:0] type_pin;
    pfm_otype_e type_val;
    logic lines_we;
    logic [3:0] lines_val;
  } pfm_sw_s;

  // External bus controller side
  typedef struct packed {
    logic ext_en;
    logic [19:0] addr;
    logic addr_phase;
    logic [7:0] p2_data;
    logic p2_data_oe;
    logic high_byte_write_strobe;
    logic verify;
  } pfm_bus_s;

  // Serial channel B and timer C side
  typedef struct packed {
    logic serial_b_transmit_out;
    logic timer_c_clkout;
    logic timer_c_clkout_en;
  } pfm_periph_s;

  // Pin drive of one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfm_pins_s;
endpackage : pfm_pkg

// ==== src/pfm_port_mux.sv ====
// Pin function multiplexer for port 1 and port 2
// How it works
// - Reset loads all port latches with ones and makes every pin quasi-bidirectional.
// - Software picks each pin's output type alone; drive follows it, and the pin is read back in every type.
// - Narrow external bus: port 1 pin 0 carries address bit 0.
// - Wide external bus: port 1 pin 0 becomes the high byte write strobe.
// - Port 1 pins 1 to 3 carry address bits 1 to 3.
// - Port 1 pin 4 feeds serial B receive; pin 5 carries serial B transmit.
// - Port 1 pin 6 is timer C count or clock out; pin 7 its control input.
// - Wide bus: port 2 carries high data byte and address lines 12 to 19.
// - Narrow bus: software sets how many address lines port 2 carries.
// - During verify the programmer drives the low address byte onto port 2.
// - The bus width strap is caught at reset release: 0 narrow, 1 wide.
`timescale 1ns/1ps
`include "pfm_map.svh"

module pfm_port_mux (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic bus_width_strap,
  input wire logic [7:0] p1_pin_in,
  input wire logic [7:0] p2_pin_in,
  input wire pfm_pkg::pfm_sw_s sw,
  input wire pfm_pkg::pfm_bus_s bus,
  input wire pfm_pkg::pfm_periph_s periph,
  output pfm_pkg::pfm_pins_s p1_pins,
  output pfm_pkg::pfm_pins_s p2_pins,
  output logic serial_b_receive_in,
  output logic timer_c_count_in,
  output logic timer_c_reload_capture_ctl,
  output logic [7:0] p1_read,
  output logic [7:0] p2_read,
  output logic [7:0] verify_addr,
  output logic bus16
);

  // Whole module state
  typedef struct packed {
    logic [7:0] p1_sync1;
    logic [7:0] p1_sync2;
    logic [7:0] p2_sync1;
    logic [7:0] p2_sync2;
    logic strap_sync1;
    logic strap_sync2;
    logic in_reset;
    logic bus16;
    logic [7:0] p1_latch;
    logic [7:0] p2_latch;
    pfm_pkg::pfm_otype_e [7:0] p1_type;
    pfm_pkg::pfm_otype_e [7:0] p2_type;
    logic [3:0] lines;
    pfm_pkg::pfm_pins_s p1;
    pfm_pkg::pfm_pins_s p2;
    logic rx;
    logic tmr_in;
    logic tmr_ctl;
    logic [7:0] p1_rd;
    logic [7:0] p2_rd;
    logic [7:0] vaddr;
  } pfm_state_s;

  pfm_state_s s;
  pfm_state_s next_s;

  // Quasi and open drain only pull low; the weak high of quasi mode is the pad's job
  function automatic logic pfm_drive_oe(input pfm_pkg::pfm_otype_e ot, input logic val);
    logic oe;
    oe = 1'b0;
    case (ot)
      pfm_pkg::PFM_QUASI: oe = ~val;
      pfm_pkg::PFM_OPEN_DRAIN: oe = ~val;
      pfm_pkg::PFM_PUSH_PULL: oe = 1'b1;
      default: oe = 1'b0;
    endcase
    return oe;
  endfunction : pfm_drive_oe

  // Next state: synchronisers, strap capture, software state, pin functions
  always_comb
  begin
    logic [7:0] v1;
    logic [7:0] v2;
    logic [7:0] bus_oe2;
    v1 = '0;
    v2 = '0;
    bus_oe2 = '0;
    next_s = s;
    // Pins come from outside; two flops before anything looks at them
    next_s.p1_sync1 = p1_pin_in;
    next_s.p1_sync2 = s.p1_sync1;
    next_s.p2_sync1 = p2_pin_in;
    next_s.p2_sync2 = s.p2_sync1;
    next_s.strap_sync1 = bus_width_strap;
    next_s.strap_sync2 = s.strap_sync1;
    // Width caught once, on the first cycle out of reset
    if (s.in_reset)
    begin
      next_s.bus16 = s.strap_sync2;
      next_s.in_reset = 1'b0;
    end
    // Software writes to latches, pin types and the line count
    if (sw.p1_latch_we)
    begin
      next_s.p1_latch = sw.latch_data;
    end
    if (sw.p2_latch_we)
    begin
      next_s.p2_latch = sw.latch_data;
    end
    if (sw.type_we && !sw.type_port)
    begin
      next_s.p1_type[sw.type_pin] = sw.type_val;
    end
    else if (sw.type_we && sw.type_port)
    begin
      next_s.p2_type[sw.type_pin] = sw.type_val;
    end
    if (sw.lines_we)
    begin
      // Counts above eight saturate so no pin index runs off the port
      next_s.lines = (sw.lines_val > `PFM_LINES_MAX) ? `PFM_LINES_MAX : sw.lines_val;
    end
    // Port 1 value: latch, gated by serial and timer outputs as on a classic port
    v1 = s.p1_latch;
    v1[`PFM_PIN_TX] = s.p1_latch[`PFM_PIN_TX] & periph.serial_b_transmit_out;
    if (periph.timer_c_clkout_en)
    begin
      v1[`PFM_PIN_TMR_IN] = s.p1_latch[`PFM_PIN_TMR_IN] & periph.timer_c_clkout;
    end
    for (int i = 0; i < `PFM_PORT_W; i++)
    begin
      next_s.p1.oe[i] = pfm_drive_oe(s.p1_type[i], v1[i]);
    end
    // Bus pins of port 1 are driven hard whatever the type says
    if (bus.ext_en)
    begin
      v1[`PFM_PIN_ADDR0] = s.bus16 ? bus.high_byte_write_strobe : bus.addr[0];
      v1[3:1] = bus.addr[3:1];
      next_s.p1.oe[3:0] = 4'hf;
    end
    next_s.p1.out = v1;
    // Port 2: latch by default
    v2 = s.p2_latch;
    if (bus.ext_en && s.bus16)
    begin
      // Address phase then high data byte on the same pins
      v2 = bus.addr_phase ? bus.addr[19:12] : bus.p2_data;
      bus_oe2 = (bus.addr_phase || bus.p2_data_oe) ? 8'hff : 8'h00;
    end
    else if (bus.ext_en)
    begin
      for (int i = 0; i < `PFM_PORT_W; i++)
      begin
        if (i < int'(s.lines))
        begin
          v2[i] = bus.addr[`PFM_P2_ADDR_LSB + i];
          bus_oe2[i] = 1'b1;
        end
      end
    end
    for (int i = 0; i < `PFM_PORT_W; i++)
    begin
      next_s.p2.oe[i] = bus_oe2[i] | pfm_drive_oe(s.p2_type[i], v2[i]);
    end
    next_s.p2.out = v2;
    // Verify: port 2 turns to input and its byte becomes the verify address
    if (bus.verify)
    begin
      next_s.p2.oe = 8'h00;
      next_s.vaddr = s.p2_sync2;
    end
    // Inputs to the peripherals and read-back of the pins
    next_s.rx = s.p1_sync2[`PFM_PIN_RX];
    next_s.tmr_in = s.p1_sync2[`PFM_PIN_TMR_IN];
    next_s.tmr_ctl = s.p1_sync2[`PFM_PIN_TMR_CTL];
    next_s.p1_rd = s.p1_sync2;
    next_s.p2_rd = s.p2_sync2;
    // Reset: synchronisers keep running so the strap is valid at release
    if (!resetn)
    begin
      next_s.in_reset = 1'b1;
      next_s.bus16 = `PFM_BUS16_RST;
      next_s.p1_latch = `PFM_LATCH_RST;
      next_s.p2_latch = `PFM_LATCH_RST;
      next_s.p1_type = '{default: pfm_pkg::PFM_QUASI};
      next_s.p2_type = '{default: pfm_pkg::PFM_QUASI};
      next_s.lines = `PFM_LINES_RST;
      next_s.p1.out = `PFM_LATCH_RST;
      next_s.p1.oe = 8'h00;
      next_s.p2.out = `PFM_LATCH_RST;
      next_s.p2.oe = 8'h00;
      next_s.rx = 1'b1;
      next_s.tmr_in = 1'b0;
      next_s.tmr_ctl = 1'b0;
      next_s.p1_rd = 8'h00;
      next_s.p2_rd = 8'h00;
      next_s.vaddr = 8'h00;
    end
  end

  // State register; reset is folded into next_s
  always_ff @(posedge clk_sys)
  begin
    s <= next_s;
  end

  // Every output straight from the state register
  assign p1_pins = s.p1;
  assign p2_pins = s.p2;
  assign serial_b_receive_in = s.rx;
  assign timer_c_count_in = s.tmr_in;
  assign timer_c_reload_capture_ctl = s.tmr_ctl;
  assign p1_read = s.p1_rd;
  assign p2_read = s.p2_rd;
  assign verify_addr = s.vaddr;
  assign bus16 = s.bus16;

  // Checks
  chk_reset_defaults: assert property (@(posedge clk_sys)
    $rose(resetn) |-> (s.p1_latch == `PFM_LATCH_RST) && (s.p2_latch == `PFM_LATCH_RST)
      && (s.p1_type == {`PFM_PORT_W{pfm_pkg::PFM_QUASI}})
      && (s.p2_type == {`PFM_PORT_W{pfm_pkg::PFM_QUASI}}))
    else $error("ports not at reset defaults after reset");

  chk_type_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    sw.type_we && !sw.type_port |=> s.p1_type[$past(sw.type_pin)] == $past(sw.type_val))
    else $error("port 1 pin type not written");

  chk_addr0_narrow: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.ext_en && !s.bus16 && !s.in_reset |=> s.p1.out[0] == $past(bus.addr[0]) && s.p1.oe[0])
    else $error("pin 0 not address bit 0 on narrow bus");

  chk_wrh_wide: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.ext_en && s.bus16 |=> s.p1.out[0] == $past(bus.high_byte_write_strobe))
    else $error("pin 0 not high byte write strobe on wide bus");

  chk_addr_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.ext_en |=> (s.p1.out[3:1] == $past(bus.addr[3:1])) && (s.p1.oe[3:1] == 3'h7))
    else $error("address bits 1 to 3 not on port 1");

  chk_serial_rx: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(resetn, 3) |-> serial_b_receive_in == $past(p1_pin_in[`PFM_PIN_RX], 3))
    else $error("serial receive not from pin 4");

  chk_timer_ctl: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(resetn, 3) |-> timer_c_reload_capture_ctl == $past(p1_pin_in[`PFM_PIN_TMR_CTL], 3))
    else $error("timer control not from pin 7");

  chk_wide_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.ext_en && s.bus16 && bus.addr_phase && !bus.verify
      |=> (s.p2.out == $past(bus.addr[19:12])) && (s.p2.oe == 8'hff))
    else $error("port 2 not carrying address 12 to 19");

  chk_narrow_lines: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.ext_en && !s.bus16 && !s.in_reset && (s.lines == 4'h8) && !bus.verify
      |=> s.p2.out == $past(bus.addr[19:12]))
    else $error("programmed address lines missing on port 2");

  chk_verify_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.verify && $past(resetn, 3) |=> (verify_addr == $past(p2_pin_in, 3)) && (s.p2.oe == 8'h00))
    else $error("verify address not taken from port 2");

  chk_width_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !s.in_reset |=> $stable(s.bus16))
    else $error("bus width changed without reset");

  cov_wide_bus: cover property (@(posedge clk_sys) disable iff (!resetn)
    s.bus16 && bus.ext_en && bus.addr_phase);
  cov_narrow_lines: cover property (@(posedge clk_sys) disable iff (!resetn)
    !s.bus16 && bus.ext_en && (s.lines != 4'h0));
  cov_verify: cover property (@(posedge clk_sys) disable iff (!resetn) bus.verify);

endmodule : pfm_port_mux

// ==== sim/pfm_pad_model.sv ====
// Pad and far side model for the port 1 / port 2 pin function mux
`timescale 1ns/1ps

module pfm_pad_model (
  input wire pfm_pkg::pfm_pins_s p1_pins,
  input wire pfm_pkg::pfm_pins_s p2_pins,
  input wire logic [7:0] p1_ext_oe,
  input wire logic [7:0] p1_ext_val,
  input wire logic prog_en,
  input wire logic [7:0] prog_byte,
  output logic [7:0] p1_pin_in,
  output logic [7:0] p2_pin_in
);
  // Released pins take the far side's drive, else float up through the weak pull-up, never hold a stale value
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      p1_pin_in[i] = p1_pins.oe[i] ? p1_pins.out[i] : (p1_ext_oe[i] ? p1_ext_val[i] : 1'h1);
      p2_pin_in[i] = p2_pins.oe[i] ? p2_pins.out[i] : (prog_en ? prog_byte[i] : 1'h1);
    end
  end
endmodule : pfm_pad_model

// ==== sim/testbench.sv ====
// Self-checking testbench for the port 1 / port 2 pin function mux
`timescale 1ns/1ps

module testbench;
  logic clk_sys = 1'h0;
  logic resetn, strap, prog_en, rx, tmr_in, tmr_ctl, bus16;
  logic [7:0] prog_byte, ext_oe, ext_val, p1_in, p2_in, p1_read, p2_read, verify_addr;
  pfm_pkg::pfm_sw_s sw = '0;
  pfm_pkg::pfm_bus_s bus;
  // Transmit idles high, timer clock out on but not enabled
  pfm_pkg::pfm_periph_s periph = 3'h6;
  pfm_pkg::pfm_pins_s p1_pins, p2_pins;
  int err_total = 0;
  int n_checks = 0;

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  pfm_port_mux uut (
    .clk_sys(clk_sys), .resetn(resetn), .bus_width_strap(strap),
    .p1_pin_in(p1_in), .p2_pin_in(p2_in), .sw(sw), .bus(bus), .periph(periph),
    .p1_pins(p1_pins), .p2_pins(p2_pins), .serial_b_receive_in(rx),
    .timer_c_count_in(tmr_in), .timer_c_reload_capture_ctl(tmr_ctl),
    .p1_read(p1_read), .p2_read(p2_read), .verify_addr(verify_addr), .bus16(bus16)
  );

  pfm_pad_model pads (
    .p1_pins(p1_pins), .p2_pins(p2_pins), .p1_ext_oe(ext_oe), .p1_ext_val(ext_val),
    .prog_en(prog_en), .prog_byte(prog_byte), .p1_pin_in(p1_in), .p2_pin_in(p2_in)
  );

  // Every drive and sample lands 2 ns after an edge, clear of the race
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // Strap is held through all of reset so the synchroniser has settled
  task automatic do_reset(input logic w);
    resetn = 1'h0;
    strap = w;
    bus = '0;
    ext_oe = 8'h00;
    ext_val = 8'h00;
    prog_en = 1'h0;
    prog_byte = 8'h00;
    tick(16);
    resetn = 1'h1;
    tick(2);
  endtask : do_reset

  // One-cycle software pulse, then one edge for the pins to follow
  task automatic sw_req(input pfm_pkg::pfm_sw_s r);
    sw = r;
    tick(1);
    sw = '0;
    tick(1);
  endtask : sw_req

  task automatic set_type(input logic port, input logic [2:0] pin, input pfm_pkg::pfm_otype_e t);
    sw_req('{type_we: 1'h1, type_port: port, type_pin: pin, type_val: t, default: '0});
  endtask : set_type

  task automatic t_reset;
    chk(p1_pins.out, 8'hff);
    chk(p1_pins.oe, 8'h00);
    chk(p2_pins.out, 8'hff);
    chk(p2_pins.oe, 8'h00);
    chk(bus16, 1'h0);
  endtask : t_reset

  // Narrow bus, address nibble odd so the strobe path would show; count saturates
  task automatic t_narrow;
    bus = '{ext_en: 1'h1, addr: 20'ha500d, default: '0};
    sw_req('{lines_we: 1'h1, lines_val: 4'h9, type_val: pfm_pkg::PFM_QUASI, default: '0});
    tick(2);
    chk(p1_pins.out, 8'hfd);
    chk(p1_pins.oe & 8'h0f, 8'h0f);
    chk(p2_pins.out, 8'ha5);
    sw_req('{lines_we: 1'h1, lines_val: 4'h3, type_val: pfm_pkg::PFM_QUASI, default: '0});
    chk(p2_pins.out, 8'hfd);
  endtask : t_narrow

  // Wide bus: strobe replaces address bit 0, port 2 muxes address and data
  task automatic t_wide;
    chk(bus16, 1'h1);
    strap = 1'h0;
    bus = '{ext_en: 1'h1, addr: 20'hfa000, addr_phase: 1'h1,
      high_byte_write_strobe: 1'h1, default: '0};
    tick(4);
    chk(bus16, 1'h1);
    chk(p1_pins.out, 8'hf1);
    chk(p2_pins.out, 8'hfa);
    chk(p2_pins.oe, 8'hff);
    bus = '{ext_en: 1'h1, addr: 20'hfa001, p2_data: 8'h3c, p2_data_oe: 1'h1, default: '0};
    tick(2);
    chk(p1_pins.out, 8'hf0);
    chk(p2_pins.out, 8'h3c);
  endtask : t_wide

  // Peripheral outputs reach their pins; far side drives the inputs
  task automatic t_periph;
    logic [7:0] pat [2] = '{8'h40, 8'h90};
    periph.serial_b_transmit_out = 1'h0;
    tick(2);
    chk(p1_pins.out, 8'hdf);
    periph = 3'h1;
    tick(2);
    chk(p1_pins.out, 8'h9f);
    periph = 3'h6;
    ext_oe = 8'hd0;
    foreach (pat[i])
    begin
      ext_val = pat[i];
      tick(4);
      chk(rx, pat[i][4]);
      chk(tmr_in, pat[i][6]);
      chk(tmr_ctl, pat[i][7]);
      chk(p1_read, pat[i] | 8'h2f);
    end
  endtask : t_periph

  // Programmer owns port 2 while verify is up; latch 00 first so port 2 drives and must let go
  task automatic t_verify;
    sw_req('{p2_latch_we: 1'h1, latch_data: 8'h00, type_val: pfm_pkg::PFM_QUASI, default: '0});
    chk(p2_pins.oe, 8'hff);
    bus.verify = 1'h1;
    prog_en = 1'h1;
    prog_byte = 8'h3c;
    tick(4);
    chk(p2_pins.oe, 8'h00);
    chk(verify_addr, 8'h3c);
    prog_byte = 8'hc3;
    tick(4);
    chk(verify_addr, 8'hc3);
    chk(p2_read, 8'hc3);
  endtask : t_verify

  // Each pin's own type decides its drive
  task automatic t_types;
    sw_req('{p1_latch_we: 1'h1, latch_data: 8'h0f, type_val: pfm_pkg::PFM_QUASI, default: '0});
    chk(p1_pins.oe, 8'hf0);
    set_type(1'h0, 3'h0, pfm_pkg::PFM_PUSH_PULL);
    set_type(1'h0, 3'h4, pfm_pkg::PFM_OPEN_DRAIN);
    set_type(1'h0, 3'h7, pfm_pkg::PFM_INPUT_ONLY);
    set_type(1'h1, 3'h0, pfm_pkg::PFM_PUSH_PULL);
    chk(p1_pins.oe, 8'h71);
    chk(p2_pins.oe, 8'h01);
  endtask : t_types

  initial
  begin
    do_reset(1'h0);
    t_reset();
    t_narrow();
    do_reset(1'h0);
    t_periph();
    t_verify();
    do_reset(1'h0);
    t_types();
    do_reset(1'h1);
    t_wide();
    end_of_test();
  end

  // Cut a hung run short
  initial
  begin
    #500000;
    err_total++;
    end_of_test();
  end
endmodule : testbench
